/* dv/t2co_pin_rx.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Clock receiver
// ----------------------------------------
module t2co_pin_rx (
	input  wire         clk_sys,       // System clock
	input  wire         aux_timer_pin, // Received clock
	output logic [19:0] half_len,      // Last half length
	output logic [15:0] edges          // Edges seen
);
	logic [19:0] run_len = 20'h00000;
	logic        last_q  = 1'b1;
	initial half_len = 20'h00000;
	initial edges = 16'h0000;
	always @(posedge clk_sys) begin
		last_q <= aux_timer_pin;
		if (aux_timer_pin != last_q) begin
			half_len <= run_len;
			run_len  <= 20'h00001;
			edges    <= edges + 16'h0001;
		end else begin
			run_len <= run_len + 20'h00001;
		end
	end
endmodule

/* dv/t2co_properties.sv */
`timescale 1ns/1ps
module t2co_properties (
	input wire       clk_sys,     // Clock
	input wire       rst,         // Reset
	input wire       reg_rd,      // Read strobe
	input wire [7:0] reg_rdata_q, // Read data
	input wire       pin_out_q,   // Pin level
	input wire       pin_oe_q,    // Pin enable
	input wire       irq_q,       // Interrupt
	input wire       baud_tick_q  // Overflow pulse
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [19:0] n_q, h_q;
	logic        v_q;
	// ----------------------------------------
	// Half tracker
	// ----------------------------------------
	// First half skipped: start value may differ from reload
	always_ff @(posedge clk_sys) begin
		if (rst || !pin_oe_q) begin
			n_q <= 20'h00000;
			h_q <= 20'h00000;
			v_q <= 1'b0;
		end else if ($changed(pin_out_q)) begin
			n_q <= 20'h00001;
			h_q <= n_q;
			v_q <= (h_q != 20'h00000);
		end else begin
			n_q <= n_q + 20'h00001;
		end
	end
	a_duty_equal: assert property (
		$changed(pin_out_q) && v_q && pin_oe_q |-> n_q == h_q)
		else $error("unequal halves");
	a_no_irq_out: assert property (
		pin_oe_q |-> !$rose(irq_q)) else $error("irq in clock-out");
	a_pin_idle_low: assert property (
		!pin_oe_q && !$past(pin_oe_q) |-> !pin_out_q)
		else $error("pin high while off");
	a_toggle_cause: assert property (
		$changed(pin_out_q) && pin_oe_q && $past(pin_oe_q)
		|-> baud_tick_q || $past(baud_tick_q)) else $error("stray toggle");
	a_tick_toggles: assert property (
		baud_tick_q && pin_oe_q |-> ##[0:1] $changed(pin_out_q) || !pin_oe_q)
		else $error("overflow without toggle");
	a_tick_single: assert property (
		baud_tick_q |=> !baud_tick_q) else $error("tick too close");
	a_read_zero: assert property (
		!$past(reg_rd) |-> reg_rdata_q == 8'h00) else $error("stray data");
	a_reset_quiet: assert property (
		$past(rst) |-> !pin_oe_q && !irq_q && !baud_tick_q)
		else $error("active after reset");
endmodule
bind t2co_clock_out t2co_properties u_props (.clk_sys, .rst, .reg_rd,
	.reg_rdata_q, .pin_out_q, .pin_oe_q, .irq_q, .baud_tick_q);

/* dv/tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module tb;
	logic        clk_sys, rst, reg_wr, reg_rd, ext_count_in, dbl;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata, d, d2;
	logic [15:0] rl, e0;
	wire  [7:0]  reg_rdata_q;
	wire         pin_out_q, pin_oe_q, irq_q, baud_tick_q;
	wire  [19:0] half_len;
	wire  [15:0] edges;
	int          fails = 0, checks_done = 0, cyc = 0;
	t2co_clock_out u_dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .ext_count_in, .reg_rdata_q, .pin_out_q, .pin_oe_q, .irq_q,
		.baud_tick_q);
	// Pulled up while the pin is released
	wire aux_timer_pin = pin_oe_q ? pin_out_q : 1'b1;
	t2co_pin_rx u_rx (.clk_sys, .aux_timer_pin, .half_len, .edges);
	// ----------------------------------------
	// Bus and checks
	// ----------------------------------------
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		v = reg_rdata_q;
	endtask
	function automatic logic [19:0] exp_half(input logic b, logic [15:0] r);
		return (20'h10000 - {4'h0, r}) * (b ? 20'h00002 : 20'h00004);
	endfunction
	task automatic end_of_test;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		ext_count_in <= 1'($urandom);
		cyc++;
		if (cyc == 10000) begin
			fails++;
			end_of_test();
		end
	end
	initial begin
		void'($urandom(32'hB3E8));
		rst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		for (int a = 0; a < 16; a++) begin
			rd(4'(a), d);
			`CHK(d, 8'h00)
		end
		for (int i = 0; i < 10; i++) begin
			dbl = (i == 0) | 1'($urandom);
			rl = (i == 0) ? 16'hFFFF : 16'hFFF8 | 16'($urandom % 8);
			wr(4'h1, 8'h02);
			wr(4'h0, 8'h00);
			wr(4'h6, {7'h00, dbl});
			wr(4'h4, rl[7:0]);
			wr(4'h5, rl[15:8]);
			wr(4'h2, 8'hF0 | 8'($urandom % 16));
			wr(4'h3, 8'hFF);
			e0 = edges;
			wr(4'h0, 8'h04);
			for (int c = 0; c < 900 && edges < e0 + 16'h3; c++)
				@(negedge clk_sys);
			`CHK(edges >= e0 + 16'h3, 1'b1)
			`CHK(half_len, exp_half(dbl, rl))
			`CHK(irq_q, 1'b0)
			wr(4'h0, 8'h00);
			rd(4'h2, d);
			rd(4'h2, d2);
			`CHK(d >= rl[7:0], 1'b1)
			`CHK(d2, d)
			wr(4'h1, 8'h00);
			repeat (3) @(negedge clk_sys);
			`CHK({pin_oe_q, pin_out_q}, 2'b00)
		end
		// Timer mode: overflows do raise the request
		wr(4'h4, 8'hFE);
		wr(4'h5, 8'hFF);
		wr(4'h2, 8'hFE);
		wr(4'h3, 8'hFF);
		wr(4'h0, 8'h04);
		repeat (20) @(negedge clk_sys);
		`CHK(irq_q, 1'b1)
		`CHK({pin_oe_q, pin_out_q}, 2'b00)
		// Stop with the flag kept, then clear it while idle
		wr(4'h0, 8'h80);
		rd(4'h0, d);
		`CHK(d, 8'h80)
		wr(4'h0, 8'h00);
		rd(4'h0, d);
		`CHK(d, 8'h00)
		`CHK(irq_q, 1'b0)
		end_of_test();
	end
endmodule

/* logic/t2co_clock_out.v */
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "t2co_regs.vh"

// Operation
// - Clock-out mode gives 50% duty clock
// - Count at half core oscillator, 16-bit
// - Overflow reloads counter from reload pair
// - No interrupt on overflow in clock-out
// - Output rate Fosc over 4*(65536-reload)
// - Drive clock onto shared timer pin
// - Count only while run bit set
// - Baud and clock-out share reload
// - Core oscillator per clock-doubling bit
module t2co_clock_out (
	input  wire       clk_sys,     // System clock, crystal rate
	input  wire       rst,         // Synchronous reset, high
	input  wire [3:0] reg_addr,    // Register address
	input  wire [7:0] reg_wdata,   // Write data
	input  wire       reg_wr,      // Write strobe
	input  wire       reg_rd,      // Read strobe
	input  wire       ext_count_in,// External count input pin
	output reg  [7:0] reg_rdata_q, // Read data, cycle after strobe
	output reg        pin_out_q,   // Timer pin output level
	output reg        pin_oe_q,    // Timer pin output enable
	output reg        irq_q,       // Overflow interrupt request
	output reg        baud_tick_q  // Overflow pulse to serial port
);

	// ----------------------------------------
	// Software state
	// ----------------------------------------
	reg  [7:0]  ctrl_q;
	reg  [7:0]  mode_q;
	reg  [7:0]  clkctl_q;
	reg  [15:0] count_q;
	reg  [15:0] reload_q;
	reg  [1:0]  ext_sync_q;
	reg         ext_prev_q;
	reg         flag_q;
	wire        tick;
	wire        run;
	wire        clk_out_mode;
	wire        inc;
	wire        ovf;
	wire        ext_rise;
	reg         flag_d;
	reg         wr_ctrl;
	reg         wr_mode;
	reg         wr_clkctl;
	reg         wr_cnt_lo;
	reg         wr_cnt_hi;
	reg         wr_rld_lo;
	reg         wr_rld_hi;

	assign run          = ctrl_q[`T2CO_CTL_RUN_BIT];
	assign clk_out_mode = mode_q[`T2CO_MODE_OE_BIT];
	assign ext_rise     = ext_sync_q[1] & ~ext_prev_q;

	t2co_tick_gen u_tick (
		.clk_sys               (clk_sys),
		.rst                   (rst),
		.clock_doubling_select (clkctl_q[`T2CO_CLK_DOUBLE_BIT]),
		.tick_q                (tick)
	);

	// Internal tick unless external count selected
	assign inc = run & (ctrl_q[`T2CO_CTL_CT_SEL_BIT] ? ext_rise : tick);
	assign ovf = inc & (count_q == 16'hFFFF);

	// ----------------------------------------
	// Pin input synchroniser
	// ----------------------------------------
	// An edge reaches the counter three clocks after the pin
	always @(posedge clk_sys) begin
		if (rst) begin
			ext_sync_q <= 2'h0;
			ext_prev_q <= 1'b0;
		end else begin
			ext_sync_q <= {ext_sync_q[0], ext_count_in};
			ext_prev_q <= ext_sync_q[1];
		end
	end

	// ----------------------------------------
	// Write decode
	// ----------------------------------------
	always @* begin
		wr_ctrl   = 1'b0;
		wr_mode   = 1'b0;
		wr_clkctl = 1'b0;
		wr_cnt_lo = 1'b0;
		wr_cnt_hi = 1'b0;
		wr_rld_lo = 1'b0;
		wr_rld_hi = 1'b0;
		if (reg_wr) begin
			if (reg_addr == `T2CO_OFS_CONTROL) begin
				wr_ctrl = 1'b1;
			end else if (reg_addr == `T2CO_OFS_MODE) begin
				wr_mode = 1'b1;
			end else if (reg_addr == `T2CO_OFS_CLOCK_CTRL) begin
				wr_clkctl = 1'b1;
			end else if (reg_addr == `T2CO_OFS_CNT_LOW) begin
				wr_cnt_lo = 1'b1;
			end else if (reg_addr == `T2CO_OFS_CNT_HIGH) begin
				wr_cnt_hi = 1'b1;
			end else if (reg_addr == `T2CO_OFS_RELOAD_LOW) begin
				wr_rld_lo = 1'b1;
			end else if (reg_addr == `T2CO_OFS_RELOAD_HIGH) begin
				wr_rld_hi = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Counter and registers
	// ----------------------------------------
	always @(posedge clk_sys) begin
		if (rst) begin
			ctrl_q   <= `T2CO_RST_BYTE;
			mode_q   <= `T2CO_RST_BYTE;
			clkctl_q <= `T2CO_RST_BYTE;
			count_q  <= `T2CO_RST_WORD;
			reload_q <= `T2CO_RST_WORD;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= reg_wdata;
			end else if (wr_mode) begin
				mode_q <= reg_wdata;
			end else if (wr_clkctl) begin
				clkctl_q <= reg_wdata;
			end else if (wr_rld_lo) begin
				reload_q[7:0] <= reg_wdata;
			end else if (wr_rld_hi) begin
				reload_q[15:8] <= reg_wdata;
			end
			// Counter write wins over a count in the same cycle
			if (wr_cnt_lo) begin
				count_q[7:0] <= reg_wdata;
			end else if (wr_cnt_hi) begin
				count_q[15:8] <= reg_wdata;
			end else if (ovf) begin
				count_q <= reload_q;
			end else if (inc) begin
				count_q <= count_q + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// Overflow flag next value
	// ----------------------------------------
	// Set beats clear; clock-out never sets it
	always @* begin
		flag_d = flag_q;
		if (ovf && !clk_out_mode) begin
			flag_d = 1'b1;
		end else if (wr_ctrl) begin
			flag_d = reg_wdata[`T2CO_CTL_FLAG_BIT];
		end
	end

	// ----------------------------------------
	// Output pin, overflow flag and pulses
	// ----------------------------------------
	always @(posedge clk_sys) begin
		if (rst) begin
			pin_out_q   <= 1'b0;
			pin_oe_q    <= 1'b0;
			flag_q      <= 1'b0;
			irq_q       <= 1'b0;
			baud_tick_q <= 1'b0;
		end else begin
			pin_oe_q <= clk_out_mode;
			// Two overflows per period give equal halves
			if (!clk_out_mode) begin
				pin_out_q <= 1'b0;
			end else if (ovf) begin
				pin_out_q <= ~pin_out_q;
			end
			// Overflow pulse stays live in clock-out mode
			baud_tick_q <= ovf;
			flag_q <= flag_d;
			// Request follows the flag with no extra cycle
			irq_q  <= flag_d;
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	// Idle cycles read zero so slaves can share an OR bus
	always @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata_q <= `T2CO_RST_BYTE;
		end else if (!reg_rd) begin
			reg_rdata_q <= `T2CO_RST_BYTE;
		end else if (reg_addr == `T2CO_OFS_CONTROL) begin
			reg_rdata_q <= {flag_q, ctrl_q[6:0]};
		end else if (reg_addr == `T2CO_OFS_MODE) begin
			reg_rdata_q <= mode_q;
		end else if (reg_addr == `T2CO_OFS_CNT_LOW) begin
			reg_rdata_q <= count_q[7:0];
		end else if (reg_addr == `T2CO_OFS_CNT_HIGH) begin
			reg_rdata_q <= count_q[15:8];
		end else if (reg_addr == `T2CO_OFS_RELOAD_LOW) begin
			reg_rdata_q <= reload_q[7:0];
		end else if (reg_addr == `T2CO_OFS_RELOAD_HIGH) begin
			reg_rdata_q <= reload_q[15:8];
		end else if (reg_addr == `T2CO_OFS_CLOCK_CTRL) begin
			reg_rdata_q <= clkctl_q;
		end else if (reg_addr == `T2CO_OFS_STATUS) begin
			reg_rdata_q <= {6'h00, pin_oe_q, pin_out_q};
		end else begin
			reg_rdata_q <= `T2CO_RST_BYTE;
		end
	end

endmodule

/* logic/t2co_regs.vh */
`ifndef T2CO_REGS_VH
`define T2CO_REGS_VH

// ----------------------------------------
// Register offsets (chosen, 8-bit data)
// ----------------------------------------
`define T2CO_ADDR_W           4
`define T2CO_OFS_CONTROL      4'h0
`define T2CO_OFS_MODE         4'h1
`define T2CO_OFS_CNT_LOW      4'h2
`define T2CO_OFS_CNT_HIGH     4'h3
`define T2CO_OFS_RELOAD_LOW   4'h4
`define T2CO_OFS_RELOAD_HIGH  4'h5
`define T2CO_OFS_CLOCK_CTRL   4'h6
`define T2CO_OFS_STATUS       4'h7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define T2CO_CTL_RUN_BIT      2
`define T2CO_CTL_CT_SEL_BIT   1
`define T2CO_CTL_FLAG_BIT     7
`define T2CO_MODE_OE_BIT      1
`define T2CO_CLK_DOUBLE_BIT   0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define T2CO_RST_BYTE         8'h00
`define T2CO_RST_WORD         16'h0000

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define T2CO_TICK_LAST_STD    2'h3

`endif

/* logic/t2co_tick_gen.v */
`timescale 1ns/1ps
`include "t2co_regs.vh"

// ----------------------------------------
// Counting tick: one pulse per two core
// oscillator periods; the core oscillator is
// the system clock halved unless doubling is on
// ----------------------------------------
module t2co_tick_gen (
	input  wire clk_sys,               // System clock (crystal rate)
	input  wire rst,                   // Synchronous reset
	input  wire clock_doubling_select, // Clock-doubling select
	output reg  tick_q                 // One-cycle count tick
);

	reg [1:0] div_q;
	reg [1:0] div_d;
	wire      wrap;

	// Period 2 with doubling, 4 without
	assign wrap = clock_doubling_select ? (div_q[0] == 1'b1) :
		(div_q == `T2CO_TICK_LAST_STD);

	always @* begin
		div_d = wrap ? 2'h0 : div_q + 2'h1;
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			div_q  <= 2'h0;
			tick_q <= 1'b0;
		end else begin
			div_q  <= div_d;
			tick_q <= wrap;
		end
	end

endmodule
